/* File: verilog/nvac_regs.vh */
// Register offsets, bit positions and timing constants of the nonvolatile access block
`ifndef NVAC_REGS_VH
`define NVAC_REGS_VH

// ==========================================================
// Register byte offsets on the APB
`define NVAC_OFF_CTRL 8'h00
`define NVAC_OFF_KEY 8'h04
`define NVAC_OFF_DATA 8'h08
`define NVAC_OFF_INDEX 8'h0C
`define NVAC_OFF_FLAG2 8'h10
`define NVAC_OFF_STATUS 8'h14

// ==========================================================
// Access control register bits
`define NVAC_B_RD 0
`define NVAC_B_WR 1
`define NVAC_B_ALLOW 2
`define NVAC_B_ABORT 3
`define NVAC_B_ERASE 4
`define NVAC_B_CFG 6
`define NVAC_B_MEM 7

// Peripheral flag register 2
`define NVAC_B_DONE 4

// Status register bits
`define NVAC_B_BUSY 4
`define NVAC_B_PWRT 3

// ==========================================================
// Unlock key values and reset values
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'hAA
`define NVAC_ERASED 8'hFF
`define NVAC_BYTE_RST 8'h00

// ==========================================================
// Timing
`define NVAC_CLK_MHZ 10
`define NVAC_WRITE_US 4000
`define NVAC_PWRT_US 64

`endif

/* File: verilog/nvac_top.v */
// Nonvolatile data array access control with APB register slave
//
// Behaviour
// - Memory select clear picks data array, set flash
// - Config select set targets configuration registers
// - Writes need write allow; allow clears at power-up
// - Abort flag sets with allow, clears on completion
// - Reset mid-write or bad attempt leaves abort set
// - Abort flag survives master clear and watchdog resets
// - Write start set-only; hardware clears at completion
// - Completion sets done flag; software or any reset clears
// - Read start refused when either select set
// - Array read lands in data register next cycle
// - Data register holds byte until read or write
// - Unlock key port stores nothing, reads zero
// - Row erase bit erases flash row, cleared when a flash row erase completes
// - Byte write erases then programs, self-timed
// - Byte-wide data register, index selects location
// - Abort keeps memory and config select bits
// - Flash writes need the same unlock sequence
// - Key 55h then AAh then write start
// - Write start blocked unless allow set earlier
// - Control, index, data locked during a write
// - Array writes blocked during power-up timer
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "nvac_regs.vh"
`default_nettype none

module nvac_top #(
	parameter AW = 8,
	parameter TW = 16,
	parameter WRITE_CYCLES = `NVAC_WRITE_US * `NVAC_CLK_MHZ,
	parameter PWRT_CYCLES = `NVAC_PWRT_US * `NVAC_CLK_MHZ
) (
	input wire clk,
	input wire rst_b,
	input wire por_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg nv_done_flag,
	output reg write_busy
);

	// ==========================================================
	// States
	localparam KS_IDLE = 2'h0;
	localparam KS_FIRST = 2'h1;
	localparam KS_ARMED = 2'h2;

	localparam PH_IDLE = 2'h0;
	localparam PH_ERASE = 2'h1;
	localparam PH_PROG = 2'h2;

	localparam [TW-1:0] ERASE_LEN = WRITE_CYCLES / 2;
	localparam [TW-1:0] PROG_LEN = WRITE_CYCLES - WRITE_CYCLES / 2;
	localparam [TW-1:0] FULL_LEN = WRITE_CYCLES;
	localparam [TW-1:0] PWRT_LEN = PWRT_CYCLES;
	localparam [TW-1:0] TMR_ONE = 1;

	function sel;
		input [7:0] addr;
		input [7:0] off;
		begin
			sel = (addr == off);
		end
	endfunction

	function known;
		input [7:0] addr;
		begin
			known = sel(addr, `NVAC_OFF_CTRL) | sel(addr, `NVAC_OFF_KEY) |
				sel(addr, `NVAC_OFF_DATA) | sel(addr, `NVAC_OFF_INDEX) |
				sel(addr, `NVAC_OFF_FLAG2) | sel(addr, `NVAC_OFF_STATUS);
		end
	endfunction

	// ==========================================================
	// Storage
	// Power-on clears everything but the array cells; master clear and watchdog clear only the part below
	wire sys_rst_b = rst_b & por_b;

	reg mem_space_sel;
	reg config_space_sel;
	reg write_abort_flag;
	reg write_allow;
	reg row_erase;
	reg write_start;
	reg read_start;
	reg [7:0] nv_data_byte;
	reg [AW-1:0] nv_byte_index;
	reg [1:0] key_state;
	reg [1:0] phase;
	reg [TW-1:0] tmr;
	reg [TW-1:0] pwrt_cnt;
	reg tgt_array;
	reg tgt_flash_erase;
	reg [AW-1:0] wr_index;
	reg [7:0] mem [0:(1<<AW)-1];

	// ==========================================================
	// Bus decode
	wire access = psel & penable & ~pready;
	wire wr_take = psel & penable & pready & pwrite & ~pslverr;
	wire pwrt_done = (pwrt_cnt == {TW{1'b0}});
	wire lo_lane = pstrb[0];
	wire wr_ctrl = wr_take & lo_lane & sel(paddr, `NVAC_OFF_CTRL) & ~write_busy;
	wire wr_key = wr_take & lo_lane & sel(paddr, `NVAC_OFF_KEY);
	wire wr_data = wr_take & lo_lane & sel(paddr, `NVAC_OFF_DATA) & ~write_busy;
	wire wr_index_reg = wr_take & lo_lane & sel(paddr, `NVAC_OFF_INDEX) & ~write_busy;
	wire wr_flag = wr_take & lo_lane & sel(paddr, `NVAC_OFF_FLAG2);

	wire new_mem = pwdata[`NVAC_B_MEM];
	wire new_cfg = pwdata[`NVAC_B_CFG];
	wire ask_wr = wr_ctrl & pwdata[`NVAC_B_WR];
	// Allow must already be set from an earlier write, and the key must be armed
	wire start_ok = ask_wr & write_allow & (key_state == KS_ARMED) &
		(pwrt_done | new_mem | new_cfg);
	wire improper = ask_wr & ~start_ok;
	wire rd_ok = wr_ctrl & pwdata[`NVAC_B_RD] & ~new_mem & ~new_cfg;
	wire finish = (phase == PH_PROG) & (tmr == TMR_ONE);

	// ==========================================================
	// Read mux
	reg [7:0] rd_byte;

	always @* begin
		rd_byte = `NVAC_BYTE_RST;
		case (paddr)
			`NVAC_OFF_CTRL: begin
				rd_byte[`NVAC_B_MEM] = mem_space_sel;
				rd_byte[`NVAC_B_CFG] = config_space_sel;
				rd_byte[`NVAC_B_ERASE] = row_erase;
				rd_byte[`NVAC_B_ABORT] = write_abort_flag;
				rd_byte[`NVAC_B_ALLOW] = write_allow;
				rd_byte[`NVAC_B_WR] = write_start;
				rd_byte[`NVAC_B_RD] = read_start;
			end
			`NVAC_OFF_KEY: begin
				rd_byte = `NVAC_BYTE_RST;
			end
			`NVAC_OFF_DATA: begin
				rd_byte = nv_data_byte;
			end
			`NVAC_OFF_INDEX: begin
				rd_byte[AW-1:0] = nv_byte_index;
			end
			`NVAC_OFF_FLAG2: begin
				rd_byte[`NVAC_B_DONE] = nv_done_flag;
			end
			`NVAC_OFF_STATUS: begin
				rd_byte[`NVAC_B_BUSY] = write_busy;
				rd_byte[`NVAC_B_PWRT] = ~pwrt_done;
				rd_byte[1:0] = key_state;
			end
			default: begin
				rd_byte = `NVAC_BYTE_RST;
			end
		endcase
	end

	// ==========================================================
	// APB answer: one wait cycle on every transfer
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access & ~known(paddr);
			prdata <= (access & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// ==========================================================
	// Power-up timer
	always @(posedge clk or negedge por_b) begin
		if (!por_b) begin
			pwrt_cnt <= PWRT_LEN;
		end else if (!pwrt_done) begin
			pwrt_cnt <= pwrt_cnt - TMR_ONE;
		end
	end

	// ==========================================================
	// Bits that survive master clear and watchdog reset
	// Only power-on clears them, so software can trace an aborted write
	always @(posedge clk or negedge por_b) begin
		if (!por_b) begin
			mem_space_sel <= 1'b0;
			config_space_sel <= 1'b0;
			write_abort_flag <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mem_space_sel <= new_mem;
				config_space_sel <= new_cfg;
			end
			if (finish) begin
				write_abort_flag <= 1'b0;
			// A started write arms it too, so a reset mid-write always shows
			end else if (improper | start_ok | (wr_ctrl & pwdata[`NVAC_B_ALLOW])) begin
				write_abort_flag <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Unlock key sequence
	// Any other bus write between the steps disarms the key, except one answered with pslverr, which is not taken
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			key_state <= KS_IDLE;
		end else if (wr_take) begin
			if (wr_key && pwdata[7:0] == `NVAC_KEY_FIRST) begin
				key_state <= KS_FIRST;
			end else if (wr_key && key_state == KS_FIRST &&
				pwdata[7:0] == `NVAC_KEY_SECOND) begin
				key_state <= KS_ARMED;
			end else begin
				key_state <= KS_IDLE;
			end
		end
	end

	// ==========================================================
	// Control bits cleared by any reset
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			write_allow <= 1'b0;
			row_erase <= 1'b0;
			write_start <= 1'b0;
			read_start <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				write_allow <= pwdata[`NVAC_B_ALLOW];
			end
			if (finish & tgt_flash_erase) begin
				row_erase <= 1'b0;
			end else if (wr_ctrl) begin
				row_erase <= pwdata[`NVAC_B_ERASE];
			end
			if (finish) begin
				write_start <= 1'b0;
			end else if (start_ok) begin
				write_start <= 1'b1;
			end
			read_start <= rd_ok;
		end
	end

	// ==========================================================
	// Data and index registers
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			nv_data_byte <= `NVAC_BYTE_RST;
			nv_byte_index <= {AW{1'b0}};
		end else begin
			if (read_start) begin
				nv_data_byte <= mem[nv_byte_index];
			end else if (wr_data) begin
				nv_data_byte <= pwdata[7:0];
			end
			if (wr_index_reg) begin
				nv_byte_index <= pwdata[AW-1:0];
			end
		end
	end

	// ==========================================================
	// Self-timed write sequencer
	// Flash and configuration targets only run the timer; their storage lives elsewhere
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			phase <= PH_IDLE;
			tmr <= {TW{1'b0}};
			write_busy <= 1'b0;
			tgt_array <= 1'b0;
			tgt_flash_erase <= 1'b0;
			wr_index <= {AW{1'b0}};
		end else begin
			case (phase)
				PH_IDLE: begin
					if (start_ok) begin
						write_busy <= 1'b1;
						wr_index <= nv_byte_index;
						tgt_array <= ~new_mem & ~new_cfg;
						tgt_flash_erase <= new_mem & ~new_cfg &
							pwdata[`NVAC_B_ERASE];
						if (~new_mem & ~new_cfg) begin
							phase <= PH_ERASE;
							tmr <= ERASE_LEN;
						end else begin
							phase <= PH_PROG;
							tmr <= FULL_LEN;
						end
					end
				end
				PH_ERASE: begin
					if (tmr == TMR_ONE) begin
						phase <= PH_PROG;
						tmr <= PROG_LEN;
					end else begin
						tmr <= tmr - TMR_ONE;
					end
				end
				PH_PROG: begin
					if (finish) begin
						phase <= PH_IDLE;
						write_busy <= 1'b0;
						tgt_array <= 1'b0;
						tgt_flash_erase <= 1'b0;
					end else begin
						tmr <= tmr - TMR_ONE;
					end
				end
				default: begin
					phase <= PH_IDLE;
					write_busy <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Array cells: no reset, contents are nonvolatile
	// A reset during programming leaves the cell erased, as a real cut-off would
	always @(posedge clk) begin
		if (tgt_array && phase == PH_ERASE && tmr == TMR_ONE) begin
			mem[wr_index] <= `NVAC_ERASED;
		end else if (tgt_array && finish) begin
			mem[wr_index] <= nv_data_byte;
		end
	end

	// ==========================================================
	// Done flag: hardware sets, software clears by writing zero
	always @(posedge clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			nv_done_flag <= 1'b0;
		end else if (finish) begin
			nv_done_flag <= 1'b1;
		end else if (wr_flag) begin
			nv_done_flag <= nv_done_flag & pwdata[`NVAC_B_DONE];
		end
	end

endmodule // nvac_top

`default_nettype wire

/* File: testbench/nvac_assertions.sv */
// Port checks for the nonvolatile access block
`include "nvac_regs.vh"
`default_nettype none
module nvac_assertions #(
	parameter int WRITE_CYCLES = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic por_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic nv_done_flag,
	input wire logic write_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BUSY_MAX = WRITE_CYCLES + 2;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !por_b);
	// ==========================================================
	// Bus answer
	sequence s_acc_start;
		psel && $rose(penable);
	endsequence
	a_ready_one_wait: assert property (s_acc_start |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_rdata_byte: assert property (prdata[31:8] == 24'h0) else $error("prdata wide");
	a_key_reads_zero: assert property (pready && !pwrite && paddr == `NVAC_OFF_KEY
		|-> prdata == 32'h0) else $error("key port not zero");
	// ==========================================================
	// Self-timed write
	a_done_at_end: assert property ($fell(write_busy) |-> nv_done_flag)
		else $error("no done flag");
	a_done_cause: assert property ($rose(nv_done_flag) |-> $fell(write_busy))
		else $error("done without write");
	a_done_sticky: assert property (nv_done_flag && !(pready && pwrite && pstrb[0]
		&& paddr == `NVAC_OFF_FLAG2 && !pwdata[`NVAC_B_DONE]) |=> nv_done_flag)
		else $error("done flag lost");
	a_busy_min: assert property ($rose(write_busy) |-> write_busy[*4])
		else $error("write too short");
	a_busy_max: assert property ($rose(write_busy) |-> ##[1:BUSY_MAX] !write_busy)
		else $error("write too long");
endmodule // nvac_assertions
`default_nettype wire

/* File: testbench/nvac_core_model.sv */
// Core-side model issuing register accesses
`include "nvac_regs.vh"
`default_nettype none
module nvac_core_model (
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic tmo);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		tmo = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// No other bus write may come between the three steps
	task automatic unlock_start(input logic [7:0] c, output logic tmo);
		logic [31:0] q;
		logic e, t1, t2;
		xfer(1'b1, `NVAC_OFF_KEY, {24'h0, `NVAC_KEY_FIRST}, q, e, t1);
		xfer(1'b1, `NVAC_OFF_KEY, {24'h0, `NVAC_KEY_SECOND}, q, e, t2);
		xfer(1'b1, `NVAC_OFF_CTRL, {24'h0, c}, q, e, tmo);
		tmo = tmo | t1 | t2;
	endtask
endmodule // nvac_core_model
`default_nettype wire

/* File: testbench/nvac_top_tb.sv */
// Self-checking bench for the nonvolatile access block
`include "nvac_regs.vh"
`default_nettype none
module nvac_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, por_b, psel, penable, pwrite, pready, pslverr, nv_done_flag, write_busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic t;
	logic [7:0] u_sel [2] = '{8'h80, 8'h40};
	int n_fail = 0;
	int comparisons = 0;
	nvac_top #(.WRITE_CYCLES(12), .PWRT_CYCLES(24)) u_dut (.clk(clk), .rst_b(rst_b),
		.por_b(por_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nv_done_flag(nv_done_flag), .write_busy(write_busy));
	nvac_core_model u_core (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic complete_run;
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang(input logic h);
		if (h !== 1'b0) begin
			n_fail++;
			$display("Error at %0t: timeout got %h expected %h", $time, h, 1'b0);
			complete_run;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		u_core.xfer(1'b1, a, {24'h0, d}, q, e, t);
		hang(t);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic err = 1'b0);
		logic [31:0] q;
		logic e;
		u_core.xfer(1'b0, a, 32'h0, q, e, t);
		hang(t);
		chk(e, err);
		if (!err) chk(q, {24'h0, exp});
	endtask
	task automatic start(input logic [7:0] c, input logic busy);
		u_core.unlock_start(c, t);
		hang(t);
		@(posedge clk);
		chk(write_busy, busy);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		hang(write_busy);
	endtask
	initial begin
		rst_b = 1'b0;
		por_b = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		@(posedge clk);
		rd(`NVAC_OFF_STATUS, 8'h08);
		rd(`NVAC_OFF_CTRL, 8'h00);
		rd(`NVAC_OFF_KEY, 8'h00);
		rd(8'h18, 8'h00, 1'b1);
		wr(`NVAC_OFF_INDEX, 8'h05);
		wr(`NVAC_OFF_DATA, 8'h3C);
		start(8'h06, 1'b0);
		rd(`NVAC_OFF_CTRL, 8'h0C);
		start(8'h06, 1'b1);
		wr(`NVAC_OFF_DATA, 8'h99);
		wr(`NVAC_OFF_INDEX, 8'h07);
		wait_idle;
		chk(nv_done_flag, 1'b1);
		rd(`NVAC_OFF_CTRL, 8'h04);
		rd(`NVAC_OFF_DATA, 8'h3C);
		rd(`NVAC_OFF_INDEX, 8'h05);
		wr(`NVAC_OFF_FLAG2, 8'h10);
		rd(`NVAC_OFF_FLAG2, 8'h10);
		wr(`NVAC_OFF_FLAG2, 8'h00);
		rd(`NVAC_OFF_FLAG2, 8'h00);
		wr(`NVAC_OFF_DATA, 8'h11);
		rd(`NVAC_OFF_DATA, 8'h11);
		wr(`NVAC_OFF_CTRL, 8'h01);
		rd(`NVAC_OFF_DATA, 8'h3C);
		rd(`NVAC_OFF_CTRL, 8'h00);
		wr(`NVAC_OFF_DATA, 8'h11);
		foreach (u_sel[i]) begin
			wr(`NVAC_OFF_CTRL, u_sel[i] | 8'h01);
			rd(`NVAC_OFF_CTRL, u_sel[i]);
			rd(`NVAC_OFF_DATA, 8'h11);
		end
		wr(`NVAC_OFF_CTRL, 8'h94);
		start(8'h96, 1'b1);
		wait_idle;
		rd(`NVAC_OFF_CTRL, 8'h84);
		start(8'h86, 1'b1);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`NVAC_OFF_CTRL, 8'h88);
		// Power-on again: an array write inside the power-up window must not start
		por_b <= 1'b0;
		@(posedge clk);
		por_b <= 1'b1;
		@(posedge clk);
		wr(`NVAC_OFF_CTRL, 8'h04);
		start(8'h06, 1'b0);
		rd(`NVAC_OFF_CTRL, 8'h0C);
		complete_run;
	end
endmodule // nvac_top_tb
bind nvac_top nvac_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
	.por_b(por_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.nv_done_flag(nv_done_flag), .write_busy(write_busy));
`default_nettype wire
